// File: rtl/ssp_port.sv
// slave-select synchronous serial port with apb register access
// assumes pins arrive asynchronous to clk_sys_i; bench resolves wires from enables
// Function
// - overrun leaves buffer undefined and raises no receive request
// - shift lsb first or msb first per bit order select
// - continuous receive: each buffer read starts the next reception
// - transmit request source is selectable
// - select enable makes the handshake pin the active-low select input
// - role select 0 is master, 1 is slave
// - slave deselected floats data output and ignores clock
// - slave selected accepts clock and drives data output
// - master with select high runs and drives the clock
// - master with select low floats pins and sets mode fault
// - mode fault keeps transfer running; mode 000b halts it
// - phase and polarity choose one of four clocking schemes
// - slave phase 0: output undefined until clocking starts
// - slave phase 1: first bit shown as soon as select falls
// - divisor written 00h wraps counter to ffh, 256 extra counts
// - readable flags: shift empty, buffer empty, rx complete, fault, overrun
// - receive enable allows reception; transmit enable allows the exchange
// - internal clock is count source over 2(m+1)
// - overrun when seventh bit arrives while previous byte unread
// - tx request on buffer load or shift done; rx request on buffer fill
`timescale 1ns/1ps
module ssp_port (
	input  wire logic           clk_sys_i,
	input  wire logic           rst_i,
	input  wire logic           psel_i,
	input  wire logic           penable_i,
	input  wire logic           pwrite_i,
	input  wire logic [7:0]     paddr_i,
	input  wire logic [31:0]    pwdata_i,
	output logic      [31:0]    prdata_o,
	output logic                pready_o,
	output logic                pslverr_o,
	input  wire logic           transfer_clock_pin_i,
	input  wire logic           slave_select_n_i,
	input  wire logic           data_in_i,
	output ssp_pkg::ssp_pins_s  pins_o,
	output logic                tx_irq_o,
	output logic                rx_irq_o
);
	import ssp_pkg::*;

	ssp_state_s s_q;
	ssp_state_s s_d;

	logic enabled;
	logic master;
	logic pha;
	logic pol;
	logic lsb_first;
	logic cnt_tick;
	logic half_tick;
	logic edge_ev;
	logic start;
	logic acc;
	logic wr;
	logic rd_rb;
	logic mapped;

	function automatic logic [7:0] shift_tx(input logic [7:0] v, input logic lsb);
		shift_tx = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] shift_rx(input logic [7:0] v, input logic b,
		input logic lsb);
		shift_rx = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction

	assign enabled   = (s_q.mode[2:0] == SMODE_SYNC) && s_q.smr3[S3_SSE];
	assign master    = !s_q.smr3[S3_ROLE_SEL];
	assign pha       = s_q.smr3[S3_CLOCK_PHASE_SEL];
	assign pol       = s_q.c0[C0_CLOCK_POLARITY_SEL];
	assign lsb_first = !s_q.c0[C0_BIT_ORDER_SEL];
	assign acc       = psel_i && penable_i;
	assign wr        = acc && pwrite_i;
	assign rd_rb     = acc && !pwrite_i && (paddr_i == ADDR_RB);
	assign mapped    = (paddr_i <= ADDR_RB) && (paddr_i[1:0] == 2'h0);

	// count source: f1, f8 or f2n prescale
	always_comb begin
		case (s_q.c0[1:0])
			2'h1: cnt_tick = (s_q.pre_cnt[2:0] == DIV_F8[2:0]);
			2'h2: cnt_tick = (s_q.pre_cnt == DIV_F2N);
			default: cnt_tick = 1'b1;
		endcase
	end

	// divisor underflow gives one half period of the internal clock
	assign half_tick = cnt_tick && !s_q.brg_fresh && (s_q.brg_cnt == 8'h00);

	// one transfer clock edge, internal or external
	always_comb begin
		if (master) begin
			edge_ev = s_q.active && half_tick;
		end else begin
			// stable level change counts only while selected
			edge_ev = s_q.active && !s_q.ss_st && (s_q.sync_clk[1] == s_q.sync_clk[2])
				&& (s_q.sync_clk[2] != s_q.clk_st);
		end
	end

	assign start = enabled && !s_q.active && s_q.c1[C1_TE] && !s_q.c1[C1_TI]
		&& (master ? s_q.ss_st : !s_q.ss_st);

	always_comb begin
		s_d = s_q;
		s_d.tx_irq = 1'b0;
		s_d.rx_irq = 1'b0;
		s_d.sync_clk = {s_q.sync_clk[1:0], transfer_clock_pin_i};
		s_d.sync_ss  = {s_q.sync_ss[1:0], slave_select_n_i};
		s_d.sync_din = {s_q.sync_din[1:0], data_in_i};
		if (s_q.sync_clk[1] == s_q.sync_clk[2]) begin
			s_d.clk_st = s_q.sync_clk[2];
		end
		if (s_q.sync_ss[1] == s_q.sync_ss[2]) begin
			s_d.ss_st = s_q.sync_ss[2];
		end
		if (s_q.sync_din[1] == s_q.sync_din[2]) begin
			s_d.din_st = s_q.sync_din[2];
		end

		s_d.pre_cnt = cnt_tick ? 5'h00 : s_q.pre_cnt + 5'h01;
		if (cnt_tick) begin
			if (s_q.brg_fresh) begin
				// first count after a write decrements, so 00h wraps to ffh
				s_d.brg_cnt   = s_q.brg_cnt - 8'h01;
				s_d.brg_fresh = 1'b0;
			end else if (s_q.brg_cnt == 8'h00) begin
				s_d.brg_cnt = s_q.brg;
			end else begin
				s_d.brg_cnt = s_q.brg_cnt - 8'h01;
			end
		end

		if (!s_q.active) begin
			s_d.sclk_lvl = !pol;
		end

		if (start) begin
			s_d.active    = 1'b1;
			s_d.rx_on     = s_q.c1[C1_RE];
			s_d.edges     = 5'h00;
			s_d.rx_bits   = 4'h0;
			s_d.ovr_frame = 1'b0;
			s_d.c1[C1_TI] = 1'b1;
			s_d.c0[C0_TX_SHIFT_EMPTY_FLAG] = 1'b0;
			s_d.tx_irq    = !s_q.c1[C1_IRS];
			s_d.tx_sh     = s_q.tb;
			if (pha) begin
				// delayed phase: first bit out before any edge
				s_d.dout  = out_bit(s_q.tb, lsb_first);
				s_d.tx_sh = shift_tx(s_q.tb, lsb_first);
			end
		end else if (edge_ev) begin
			s_d.edges    = s_q.edges + 5'h01;
			s_d.sclk_lvl = !s_q.sclk_lvl;
			if (s_q.edges[0] == pha) begin
				// phase 0 leading edge and phase 1 trailing edge shift out
				s_d.dout  = out_bit(s_q.tx_sh, lsb_first);
				s_d.tx_sh = shift_tx(s_q.tx_sh, lsb_first);
			end else begin
				s_d.rx_sh   = shift_rx(s_q.rx_sh, s_q.din_st, lsb_first);
				s_d.rx_bits = s_q.rx_bits + 4'h1;
				if (s_q.rx_on && (s_q.rx_bits + 4'h1 == OVR_BITS) && s_q.c1[C1_RI]) begin
					s_d.ovr_frame  = 1'b1;
					s_d.rb[RB_OER] = 1'b1;
				end
				if (s_q.rx_on && (s_q.rx_bits + 4'h1 == BYTE_BITS)) begin
					s_d.rb[7:0] = shift_rx(s_q.rx_sh, s_q.din_st, lsb_first);
					s_d.c1[C1_RI] = 1'b1;
					// after an overrun the buffer holds junk and no request goes out
					s_d.rx_irq = !s_q.ovr_frame && !s_d.ovr_frame;
				end
			end
			if (s_q.edges + 5'h01 == EDGES_BYTE) begin
				s_d.active = 1'b0;
				s_d.c0[C0_TX_SHIFT_EMPTY_FLAG] = 1'b1;
				s_d.tx_irq = s_q.c1[C1_IRS];
			end
		end

		// mode fault is sticky; the running transfer keeps going
		if (wr && (paddr_i == ADDR_SMR3)) begin
			s_d.smr3 = {pwdata_i[7:5], pwdata_i[S3_ERR] & s_q.smr3[S3_ERR], pwdata_i[3:0]};
		end
		if (enabled && master && !s_q.ss_st) begin
			s_d.smr3[S3_ERR] = 1'b1;
		end

		if (wr) begin
			case (paddr_i)
				ADDR_MODE: s_d.mode = pwdata_i[7:0];
				ADDR_C0: begin
					s_d.c0 = {pwdata_i[7:4], s_d.c0[C0_TX_SHIFT_EMPTY_FLAG], pwdata_i[2:0]};
				end
				ADDR_C1: begin
					s_d.c1 = {pwdata_i[7:4], s_d.c1[C1_RI], pwdata_i[2], s_d.c1[C1_TI],
						pwdata_i[0]};
				end
				ADDR_SMR:  s_d.smr  = pwdata_i[7:0];
				ADDR_SMR2: s_d.smr2 = pwdata_i[7:0];
				ADDR_SMR4: s_d.smr4 = pwdata_i[7:0];
				ADDR_IFS:  s_d.ifs  = pwdata_i[7:0];
				ADDR_BRG: begin
					s_d.brg       = pwdata_i[7:0];
					s_d.brg_cnt   = pwdata_i[7:0];
					s_d.brg_fresh = 1'b1;
				end
				ADDR_TB: begin
					s_d.tb        = pwdata_i[7:0];
					s_d.c1[C1_TI] = 1'b0;
				end
				default: begin
				end
			endcase
		end

		if (rd_rb) begin
			// a fill in the same cycle keeps the flag set
			s_d.c1[C1_RI] = s_d.rx_irq | (s_q.active && s_d.c1[C1_RI] && !s_q.c1[C1_RI]);
			if (s_q.c1[C1_RRM] && s_q.c1[C1_TI]) begin
				// continuous receive: the read re-arms the exchange with the old byte
				s_d.c1[C1_TI] = 1'b0;
			end
		end
		if (!s_q.c1[C1_RE] && !s_d.ovr_frame) begin
			s_d.rb[RB_OER] = 1'b0;
		end

		if (!enabled) begin
			// any mode other than 001b, or a cleared select enable, halts a transfer
			s_d.active = 1'b0;
			s_d.c0[C0_TX_SHIFT_EMPTY_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.mode     <= RST_MODE;
			s_q.c0       <= RST_C0;
			s_q.c1       <= RST_C1;
			s_q.smr      <= RST_BYTE;
			s_q.rb       <= RST_RB;
			s_q.sync_clk <= 3'h7;
			s_q.sync_ss  <= 3'h7;
			s_q.clk_st   <= 1'b1;
			s_q.ss_st    <= 1'b1;
			s_q.sclk_lvl <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// bus answer: zero wait, error on unmapped or misaligned address
	assign pready_o  = 1'b1;
	assign pslverr_o = acc && !mapped;
	always_comb begin
		prdata_o = 32'h0000_0000;
		case (paddr_i)
			ADDR_MODE: prdata_o[7:0]  = s_q.mode;
			ADDR_C0:   prdata_o[7:0]  = s_q.c0;
			ADDR_C1:   prdata_o[7:0]  = s_q.c1;
			ADDR_SMR:  prdata_o[7:0]  = s_q.smr;
			ADDR_SMR2: prdata_o[7:0]  = s_q.smr2;
			ADDR_SMR3: prdata_o[7:0]  = s_q.smr3;
			ADDR_SMR4: prdata_o[7:0]  = s_q.smr4;
			ADDR_BRG:  prdata_o[7:0]  = s_q.brg;
			ADDR_IFS:  prdata_o[7:0]  = s_q.ifs;
			ADDR_RB:   prdata_o[15:0] = s_q.rb;
			default:   prdata_o = 32'h0000_0000;
		endcase
	end

	always_comb begin
		pins_o.sclk    = s_q.sclk_lvl;
		pins_o.sclk_oe = enabled && master && s_q.ss_st;
		pins_o.mdo     = s_q.dout;
		pins_o.mdo_oe  = enabled && master && s_q.ss_st;
		pins_o.sdo     = s_q.dout;
		pins_o.sdo_oe  = enabled && !master && !s_q.ss_st;
	end
	assign tx_irq_o = s_q.tx_irq;
	assign rx_irq_o = s_q.rx_irq;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	sequence s_slave_start;
		start && !master && pha;
	endsequence

	sequence s_frame_end;
		edge_ev && (s_q.edges == 5'h0f);
	endsequence

	property p_ovr_quiet;
		s_q.ovr_frame |-> !rx_irq_o;
	endproperty
	a_ovr_quiet: assert property (p_ovr_quiet) else $error("rx request after overrun");

	property p_slave_float;
		enabled && !master && s_q.ss_st |-> !pins_o.sdo_oe && !edge_ev;
	endproperty
	a_slave_float: assert property (p_slave_float) else $error("slave drives deselected");

	property p_slave_drive;
		enabled && !master && !s_q.ss_st |-> pins_o.sdo_oe && !pins_o.sclk_oe;
	endproperty
	a_slave_drive: assert property (p_slave_drive) else $error("slave silent when selected");

	property p_master_clk;
		enabled && master && s_q.ss_st |-> pins_o.sclk_oe && pins_o.mdo_oe;
	endproperty
	a_master_clk: assert property (p_master_clk) else $error("master not driving clock");

	property p_fault;
		enabled && master && !s_q.ss_st |-> !pins_o.sclk_oe ##1 s_q.smr3[S3_ERR];
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not flagged");

	property p_no_abort;
		s_q.active && enabled && !(edge_ev && (s_q.edges == 5'h0f)) |=> s_q.active;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("transfer dropped");

	property p_halt;
		!enabled |=> !s_q.active && s_q.c0[C0_TX_SHIFT_EMPTY_FLAG];
	endproperty
	a_halt: assert property (p_halt) else $error("transfer survives disable");

	property p_txirq_load;
		start && !s_q.c1[C1_IRS] |=> tx_irq_o && s_q.c1[C1_TI] ##1 !tx_irq_o;
	endproperty
	a_txirq_load: assert property (p_txirq_load) else $error("no tx request on load");

	property p_txirq_done;
		(s_frame_end and enabled) |=> s_q.c0[C0_TX_SHIFT_EMPTY_FLAG] && (tx_irq_o == s_q.c1[C1_IRS]);
	endproperty
	a_txirq_done: assert property (p_txirq_done) else $error("bad tx request at end");

	property p_pha1_first;
		s_slave_start |=> s_q.dout == (lsb_first ? $past(s_q.tb[0]) : $past(s_q.tb[7]));
	endproperty
	a_pha1_first: assert property (p_pha1_first) else $error("first bit not shown");

	property p_brg_wrap;
		cnt_tick && s_q.brg_fresh && (s_q.brg_cnt == 8'h00) && !wr |=> s_q.brg_cnt == 8'hff;
	endproperty
	a_brg_wrap: assert property (p_brg_wrap) else $error("divisor did not wrap");

	property p_rx_flag;
		rx_irq_o |-> s_q.c1[C1_RI];
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("rx request without flag");

endmodule

// File: rtl/ssp_pkg.sv
// constants, register map and state carrier for the slave-select serial port
// assumes a 32-bit apb slave with one aligned word per 8- or 16-bit register
package ssp_pkg;

	localparam logic [7:0]  ADDR_MODE  = 8'h00;
	localparam logic [7:0]  ADDR_C0    = 8'h04;
	localparam logic [7:0]  ADDR_C1    = 8'h08;
	localparam logic [7:0]  ADDR_SMR   = 8'h0c;
	localparam logic [7:0]  ADDR_SMR2  = 8'h10;
	localparam logic [7:0]  ADDR_SMR3  = 8'h14;
	localparam logic [7:0]  ADDR_SMR4  = 8'h18;
	localparam logic [7:0]  ADDR_BRG   = 8'h1c;
	localparam logic [7:0]  ADDR_IFS   = 8'h20;
	localparam logic [7:0]  ADDR_TB    = 8'h24;
	localparam logic [7:0]  ADDR_RB    = 8'h28;

	// mode register fields
	localparam int          MODE_CKSRC = 3;
	localparam logic [2:0]  SMODE_OFF  = 3'h0;
	localparam logic [2:0]  SMODE_SYNC = 3'h1;
	// control0 fields
	localparam int          C0_TX_SHIFT_EMPTY_FLAG   = 3;
	localparam int          C0_CLOCK_POLARITY_SEL   = 6;
	localparam int          C0_BIT_ORDER_SEL   = 7;
	// control1 fields
	localparam int          C1_TE      = 0;
	localparam int          C1_TI      = 1;
	localparam int          C1_RE      = 2;
	localparam int          C1_RI      = 3;
	localparam int          C1_IRS     = 4;
	localparam int          C1_RRM     = 5;
	// special mode3 fields
	localparam int          S3_SSE     = 0;
	localparam int          S3_CLOCK_PHASE_SEL    = 1;
	localparam int          S3_ROLE_SEL    = 2;
	localparam int          S3_ERR     = 4;
	// receive buffer overrun bit
	localparam int          RB_OER     = 12;

	localparam logic [7:0]  RST_MODE   = 8'h00;
	localparam logic [7:0]  RST_C0     = 8'h08;
	localparam logic [7:0]  RST_C1     = 8'h02;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_RB     = 16'h0000;

	// count source prescale terminal counts, in system clocks; then frame edge and bit counts
	localparam logic [4:0]  DIV_F8     = 5'h07;
	localparam logic [4:0]  DIV_F2N    = 5'h1f;
	localparam logic [4:0]  EDGES_BYTE = 5'h10;
	localparam logic [3:0]  OVR_BITS   = 4'h7;
	localparam logic [3:0]  BYTE_BITS  = 4'h8;

	typedef struct packed {
		logic sclk;
		logic sclk_oe;
		logic mdo;
		logic mdo_oe;
		logic sdo;
		logic sdo_oe;
	} ssp_pins_s;

	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  c0;
		logic [7:0]  c1;
		logic [7:0]  smr;
		logic [7:0]  smr2;
		logic [7:0]  smr3;
		logic [7:0]  smr4;
		logic [7:0]  brg;
		logic [7:0]  ifs;
		logic [7:0]  tb;
		logic [15:0] rb;
		logic [4:0]  pre_cnt;
		logic [7:0]  brg_cnt;
		logic        brg_fresh;
		logic        active;
		logic        rx_on;
		logic        ovr_frame;
		logic [4:0]  edges;
		logic [3:0]  rx_bits;
		logic [7:0]  tx_sh;
		logic [7:0]  rx_sh;
		logic        sclk_lvl;
		logic        dout;
		logic [2:0]  sync_clk;
		logic [2:0]  sync_ss;
		logic [2:0]  sync_din;
		logic        clk_st;
		logic        ss_st;
		logic        din_st;
		logic        tx_irq;
		logic        rx_irq;
	} ssp_state_s;

endpackage

// File: sim/ssp_peer.sv
// peer controller on the serial link: master or slave, behavioural
// assumes the bench arms it before each frame and reads got afterwards
`timescale 1ns/1ps
module ssp_peer (
	input  wire logic                clk_sys_i,
	input  wire ssp_pkg::ssp_pins_s  pins_i,
	output logic                     clk_line_o,
	output logic                     ss_n_o,
	output logic                     din_o
);
	import ssp_pkg::*;
	logic       ph;
	logic       pol;
	logic       m_clk;
	logic       last;
	logic [7:0] sbits;
	logic [7:0] got;
	int         nedge;
	int         k;
	realtime    t1;
	realtime    t2;
	wire logic  dout = pins_i.mdo_oe ? pins_i.mdo : (pins_i.sdo_oe ? pins_i.sdo : ~last);
	assign clk_line_o = pins_i.sclk_oe ? pins_i.sclk : m_clk;
	initial begin
		m_clk = 1'b1;
		ss_n_o = 1'b1;
		din_o = 1'b0;
		last = 1'b0;
		nedge = 0;
		ph = 1'b0;
		pol = 1'b0;
		sbits = 8'h00;
	end
	// released data line shows the inverse of its last driven level
	always @(posedge clk_sys_i) if (pins_i.mdo_oe || pins_i.sdo_oe) last <= dout;
	// odd edges lead; phase decides which edge shifts out and which samples
	always @(clk_line_o) begin
		nedge++;
		k = nedge;
		if (k == 1) t1 = $realtime;
		if (k == 2) t2 = $realtime;
		if (k <= 16 && ((k % 2 == 1) ^ ph) && k / 2 < 8) din_o <= sbits[k / 2];
		if (k <= 16 && !((k % 2 == 1) ^ ph)) got[ph ? k / 2 : k / 2 - 1] = dout;
	end
	task automatic arm(input logic p, input logic q, input logic [7:0] b);
		m_clk <= ~q;
		@(posedge clk_sys_i);
		ph = p;
		pol = q;
		sbits = b;
		din_o <= p ? b[0] : ~din_o;
		nedge = 0;
		got = 8'h00;
	endtask
	task automatic sel(input logic v);
		ss_n_o <= v;
	endtask
	// peer as master: 16 clock edges, half period h system clocks, then idle
	task automatic run(input int h);
		for (int e = 0; e < 16; e++) begin
			repeat (h) @(posedge clk_sys_i);
			m_clk <= ~m_clk;
		end
		repeat (h) @(posedge clk_sys_i);
	endtask
endmodule

// File: sim/ssp_port_test.sv
// self-checking bench for the serial port: apb tasks plus a link peer
// assumes apb slave raises pready within 50 cycles; pins resolved inside the peer model
`timescale 1ns/1ps
module ssp_port_test;
	import ssp_pkg::*;
	logic        clk_sys_i;
	logic        rst_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        perr;
	ssp_pins_s   pins;
	logic        tx_irq;
	logic        rx_irq;
	logic        clk_line;
	logic        ss_n;
	logic        din;
	logic [15:0] rv;
	logic        ph;
	logic        pol;
	logic        msb;
	logic        irs;
	logic [7:0]  tbb;
	logic [7:0]  rxb;
	int          num_errors = 0;
	int          n_tests = 0;
	int          ntx;
	int          nrx;
	int          txat;
	ssp_port dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .transfer_clock_pin_i(clk_line),
		.slave_select_n_i(ss_n), .data_in_i(din), .pins_o(pins), .tx_irq_o(tx_irq),
		.rx_irq_o(rx_irq));
	ssp_peer peer_u (.clk_sys_i(clk_sys_i), .pins_i(pins), .clk_line_o(clk_line),
		.ss_n_o(ss_n), .din_o(din));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (tx_irq === 1'b1) begin
			ntx++;
			txat = peer_u.nedge;
		end
		if (rx_irq === 1'b1) nrx++;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		// upper lanes carry junk the port must ignore
		pwdata <= {~d, d, ~d, d};
		@(posedge clk_sys_i);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_i);
			if (pready === 1'b1) break;
		end
		rv = prdata[15:0];
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
		if (n == 50) begin
			chk("pready", 16'h0001, 16'h0000);
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	// bounded wait for the peer to see n clock edges, then let the flags land
	task automatic wait_edges(input int n);
		int i;
		for (i = 0; i < 4000 && peer_u.nedge < n; i++) @(posedge clk_sys_i);
		if (i == 4000) begin
			chk("edges", 16'(n), 16'(peer_u.nedge));
			wrap_up();
		end
		repeat (12) @(posedge clk_sys_i);
	endtask
	function automatic logic [7:0] wire_order(input logic [7:0] b, input logic m);
		for (int k = 0; k < 8; k++) wire_order[k] = m ? b[7 - k] : b[k];
	endfunction
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		chk("watchdog", 16'h0000, 16'h0001);
		wrap_up();
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		rd(ADDR_MODE); chk("mode", {8'h00, RST_MODE}, rv);
		rd(ADDR_C0); chk("c0", {8'h00, RST_C0}, rv);
		rd(ADDR_C1); chk("c1", {8'h00, RST_C1}, rv);
		rd(ADDR_RB); chk("rb", RST_RB, rv);
		rd(8'h2c); chk("unmapped", 16'h0001, {15'h0000, perr});
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			ph = i[0];
			pol = i[1];
			msb = i[0] ^ i[1];
			irs = i[0];
			tbb = 8'h3a ^ 8'(i);
			rxb = 8'hc5 ^ 8'(i);
			wr(ADDR_MODE, 8'h01);
			wr(ADDR_C0, {msb, pol, 6'h00});
			wr(ADDR_BRG, 8'h07);
			wr(ADDR_SMR3, {6'h00, ph, 1'b1});
			wr(ADDR_C1, {3'h0, irs, 4'h5});
			peer_u.arm(ph, pol, wire_order(rxb, msb));
			ntx = 0;
			nrx = 0;
			wr(ADDR_TB, tbb);
			wait_edges(16);
			chk("mosi", {8'h00, wire_order(tbb, msb)}, {8'h00, peer_u.got});
			chk("half_ns", 16'd40, 16'(int'(peer_u.t2 - peer_u.t1)));
			chk("tx_at", irs ? 16'd16 : 16'd0, 16'(txat));
			chk("irq_n", 16'h0101, {8'(ntx), 8'(nrx)});
			rd(ADDR_C0); chk("tx_shift_empty_flag", 16'h0001, {15'h0000, rv[C0_TX_SHIFT_EMPTY_FLAG]});
			rd(ADDR_C1); chk("ti_ri", 16'h0003, {14'h0000, rv[C1_TI], rv[C1_RI]});
			rd(ADDR_RB); chk("rx", {3'h0, 1'b0, 4'h0, rxb}, {3'h0, rv[RB_OER], 4'h0, rv[7:0]});
			$display("test master %0d done", i);
		end
		nrx = 0;
		peer_u.arm(1'b1, 1'b1, 8'h0f);
		wr(ADDR_TB, 8'h11);
		wait_edges(16);
		peer_u.arm(1'b1, 1'b1, 8'hf0);
		wr(ADDR_TB, 8'h22);
		wait_edges(16);
		rd(ADDR_RB); chk("overrun", 16'h0001, {15'h0000, rv[RB_OER]});
		chk("rx_irq_n", 16'd1, 16'(nrx));
		wr(ADDR_C1, 8'h00);
		wr(ADDR_C1, 8'h25);
		peer_u.arm(1'b1, 1'b1, 8'h5c);
		rd(ADDR_RB);
		wait_edges(16);
		chk("dummy", 16'h0022, {8'h00, peer_u.got});
		// continuous receive off, so the read below re-arms nothing
		wr(ADDR_C1, 8'h05);
		rd(ADDR_RB); chk("cont_rx", 16'h005c, {8'h00, rv[7:0]});
		$display("test overrun and continuous done");
		wr(ADDR_C0, 8'h00);
		wr(ADDR_SMR3, 8'h01);
		wr(ADDR_C1, 8'h05);
		peer_u.arm(1'b0, 1'b0, 8'h00);
		wr(ADDR_TB, 8'h96);
		wait_edges(4);
		peer_u.sel(1'b0);
		repeat (8) @(posedge clk_sys_i);
		chk("fault_oe", 16'h0000, {14'h0000, pins.sclk_oe, pins.mdo_oe});
		rd(ADDR_SMR3); chk("fault", 16'h0001, {15'h0000, rv[S3_ERR]});
		rd(ADDR_C0); chk("fault_busy", 16'h0000, {15'h0000, rv[C0_TX_SHIFT_EMPTY_FLAG]});
		for (int j = 0; j < 60 && rv[C0_TX_SHIFT_EMPTY_FLAG] !== 1'b1; j++) rd(ADDR_C0);
		chk("fault_runs", 16'h0001, {15'h0000, rv[C0_TX_SHIFT_EMPTY_FLAG]});
		peer_u.sel(1'b1);
		// select needs the synchroniser delay before the clear can win
		repeat (8) @(posedge clk_sys_i);
		wr(ADDR_SMR3, 8'h01);
		rd(ADDR_SMR3); chk("fault_clr", 16'h0000, {15'h0000, rv[S3_ERR]});
		$display("test mode fault done");
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		rd(ADDR_SMR3); chk("rst_smr3", {8'h00, RST_BYTE}, rv);
		rd(ADDR_C1); chk("rst_c1", {8'h00, RST_C1}, rv);
		wr(ADDR_MODE, 8'h09);
		wr(ADDR_BRG, 8'h00);
		wr(ADDR_SMR3, 8'h07);
		wr(ADDR_C1, 8'h05);
		wr(ADDR_TB, 8'h4b);
		peer_u.arm(1'b1, 1'b0, 8'hb4);
		peer_u.run(20);
		chk("desel_oe", 16'h0000, {15'h0000, pins.sdo_oe});
		rd(ADDR_C1); chk("desel_ri", 16'h0000, {15'h0000, rv[C1_RI]});
		peer_u.arm(1'b1, 1'b0, 8'hb4);
		peer_u.sel(1'b0);
		repeat (10) @(posedge clk_sys_i);
		chk("first_bit", 16'h0003, {14'h0000, pins.sdo_oe, pins.sdo});
		peer_u.run(20);
		peer_u.sel(1'b1);
		chk("miso", 16'h004b, {8'h00, peer_u.got});
		rd(ADDR_RB); chk("slave_rx", 16'h00b4, {8'h00, rv[7:0]});
		$display("test slave done");
		wrap_up();
	end
endmodule
